/* bbr_host_model.sv */
// Host microcontroller model driving the serial register pins
`timescale 1ns/100ps
module bbr_host_model (
  // System
  input wire logic clk,
  // Serial pins
  output logic spiClk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe
);
  // Six clocks a phase keeps clear of the two-flop synchroniser
  int halfClk = 6;

  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // ***********************************************************************
  // One two-byte frame, pins move only at falling clk edges
  // ***********************************************************************
  task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {wr, addr, wdata};
    if (wr && addr == bbr_pkg::ADDR_RATE) bits[7:3] = 5'h00;
    if (wr && addr == bbr_pkg::ADDR_PIN) bits[7:2] = 6'h00;
    rdata = 8'h00;
    @(negedge clk);
    spiCsN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spiMosi = bits[i];
      repeat (halfClk) @(negedge clk);
      // Undriven read data must not pass as a bit
      if (i < 8) rdata = {rdata[6:0], spiMisoOe ? spiMiso : 1'bx};
      spiClk = 1'b1;
      repeat (halfClk) @(negedge clk);
      spiClk = 1'b0;
    end
    repeat (halfClk) @(negedge clk);
    spiCsN = 1'b1;
    // Released data line does not keep its last value
    spiMosi = ~spiMosi;
    repeat (halfClk) @(negedge clk);
  endtask
endmodule // bbr_host_model

/* bbr_irq_pin.sv */
// Interrupt pin driver with four drive styles
`timescale 1ns/100ps
module bbr_irq_pin (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic [1:0] pinMode,
  input wire logic irqRequest,
  // Pin
  output logic irqOut,
  output logic irqOe
);

  // ***********************************************************************
  // Drive decode
  // ***********************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqOut <= 1'b0;
      irqOe <= 1'b1;
    end else begin
      case (bbr_pkg::bbr_pin_mode_t'(pinMode))
        bbr_pkg::PIN_OPEN_SOURCE: begin
          irqOut <= 1'b1;
          irqOe <= irqRequest;
        end
        bbr_pkg::PIN_OPEN_DRAIN: begin
          irqOut <= 1'b0;
          irqOe <= irqRequest;
        end
        bbr_pkg::PIN_CMOS: begin
          irqOut <= irqRequest;
          irqOe <= 1'b1;
        end
        default: begin
          irqOut <= ~irqRequest;
          irqOe <= 1'b1;
        end
      endcase
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  AST_FLOAT_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
    pinMode[1] |=> (irqOe == $past(irqRequest)) && (irqOut == $past(pinMode[0])))
    else $error("open drive pin misbehaves");
  AST_PUSH_PULL: assert property (@(posedge clk) disable iff (!nrst)
    !pinMode[1] |=> irqOe && (irqOut == ($past(irqRequest) ~^ $past(pinMode[0]))))
    else $error("push-pull pin misbehaves");

endmodule // bbr_irq_pin

/* bbr_pkg.sv */
// Shared constants and types for the baseband rate and interrupt-pin configuration block
package bbr_pkg;

  // ***********************************************************************
  // Register map
  // ***********************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] ADDR_CODE_CTRL = 7'h03;
  localparam logic [6:0] ADDR_RATE = 7'h04;
  localparam logic [6:0] ADDR_PIN = 7'h05;
  localparam logic [7:0] RST_CODE_CTRL = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_PIN = 8'h01;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  localparam int CTRL_HALF_BIT = 5;
  localparam int RATE_LEN32_BIT = 2;
  localparam int RATE_DOUBLE_BIT = 1;
  localparam int RATE_OVS_BIT = 0;
  localparam int PIN_FIELD_LSB = 0;
  localparam logic [2:0] RATE_BAD_A = 3'h1;
  localparam logic [2:0] RATE_BAD_B = 3'h2;

  // ***********************************************************************
  // Code and sampling figures
  // ***********************************************************************
  localparam logic [6:0] CHIPS_SHORT = 7'h20;
  localparam logic [6:0] CHIPS_LONG = 7'h40;
  localparam logic [3:0] OVS_LOW = 4'h6;
  localparam logic [3:0] OVS_HIGH = 4'hc;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NORMAL_BIT_NS = 31250;
  localparam int DOUBLE_SYM_NS = 32000;
  localparam int LONG_BIT_NS = 62500;
  localparam int NORMAL_BIT_CYCLES = NORMAL_BIT_NS / CLK_PERIOD_NS;
  localparam int DOUBLE_SYM_CYCLES = DOUBLE_SYM_NS / CLK_PERIOD_NS;
  localparam int LONG_BIT_CYCLES = LONG_BIT_NS / CLK_PERIOD_NS;
  localparam int PERIOD_W = 13;

  // ***********************************************************************
  // Types
  // ***********************************************************************
  typedef enum logic [1:0] {
    PIN_CMOS_INV = 2'h0,
    PIN_CMOS = 2'h1,
    PIN_OPEN_DRAIN = 2'h2,
    PIN_OPEN_SOURCE = 2'h3
  } bbr_pin_mode_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'h0,
    SPI_ADDR = 2'h1,
    SPI_DATA = 2'h3,
    SPI_DONE = 2'h2
  } bbr_spi_state_t;

endpackage

/* bbr_rate_config.sv */
// Top of the rate, oversampling and interrupt-pin configuration block
`timescale 1ns/100ps

module bbr_rate_config #(
  parameter int LONG_BIT_CYCLES = bbr_pkg::LONG_BIT_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Serial register pins
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // Code store and interrupt source
  input wire logic [63:0] pnCode,
  input wire logic irqRequest,
  // Interrupt pin
  output logic irqOut,
  output logic irqOe,
  // Effective baseband setup
  output logic [6:0] chipsPerBit,
  output logic [1:0] bitsPerSymbol,
  output logic [3:0] oversample,
  output logic [31:0] primaryCode,
  output logic [31:0] secondaryCode,
  output logic symbolTick,
  output logic configInvalid
);

  // ***********************************************************************
  // Register port
  // ***********************************************************************
  logic [6:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic regWrite;

  bbr_spi_slave u_spi (
    .clk(clk),
    .nrst(nrst),
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRdData(regRdData)
  );

  // ***********************************************************************
  // Registers
  // ***********************************************************************
  logic [7:0] codeCtrl, rateCfg, pinCfg;

  // Rate and pin upper bits are stored as written, the host keeps them zero; control keeps only bit 5
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      codeCtrl <= bbr_pkg::RST_CODE_CTRL;
      rateCfg <= bbr_pkg::RST_RATE;
      pinCfg <= bbr_pkg::RST_PIN;
    end else if (regWrite) begin
      case (regAddr)
        bbr_pkg::ADDR_CODE_CTRL: codeCtrl <= regWrData & (8'h01 << bbr_pkg::CTRL_HALF_BIT);
        bbr_pkg::ADDR_RATE: rateCfg <= regWrData;
        bbr_pkg::ADDR_PIN: pinCfg <= regWrData;
        default: codeCtrl <= codeCtrl;
      endcase
    end
  end

  function automatic logic [7:0] readMux(input logic [6:0] addr, input logic [7:0] ctrl,
                                         input logic [7:0] rate, input logic [7:0] pin);
    case (addr)
      bbr_pkg::ADDR_CODE_CTRL: readMux = ctrl;
      bbr_pkg::ADDR_RATE: readMux = rate;
      bbr_pkg::ADDR_PIN: readMux = pin;
      default: readMux = bbr_pkg::READ_UNMAPPED;
    endcase
  endfunction

  assign regRdData = readMux(regAddr, codeCtrl, rateCfg, pinCfg);

  // ***********************************************************************
  // Mode decode
  // ***********************************************************************
  logic len32, dbl, ovs12, halfUpper, badCfg;
  logic [2:0] rateField;
  assign rateField = rateCfg[2:0];
  assign len32 = rateCfg[bbr_pkg::RATE_LEN32_BIT];
  // Double bit ignored with long codes
  assign dbl = len32 & rateCfg[bbr_pkg::RATE_DOUBLE_BIT];
  assign ovs12 = len32 & ~dbl & rateCfg[bbr_pkg::RATE_OVS_BIT];
  assign halfUpper = codeCtrl[bbr_pkg::CTRL_HALF_BIT];
  // Illegal patterns fall back to plain 64-chip decode; flagged for software
  assign badCfg = (rateField == bbr_pkg::RATE_BAD_A) || (rateField == bbr_pkg::RATE_BAD_B);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chipsPerBit <= bbr_pkg::CHIPS_LONG;
      bitsPerSymbol <= 2'h1;
      oversample <= bbr_pkg::OVS_LOW;
      configInvalid <= 1'b0;
    end else begin
      chipsPerBit <= len32 ? bbr_pkg::CHIPS_SHORT : bbr_pkg::CHIPS_LONG;
      bitsPerSymbol <= dbl ? 2'h2 : 2'h1;
      oversample <= ovs12 ? bbr_pkg::OVS_HIGH : bbr_pkg::OVS_LOW;
      configInvalid <= badCfg;
    end
  end

  // ***********************************************************************
  // Code routing
  // ***********************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      primaryCode <= 32'h0000_0000;
      secondaryCode <= 32'h0000_0000;
    end else if (dbl || !len32) begin
      primaryCode <= pnCode[31:0];
      secondaryCode <= pnCode[63:32];
    end else if (halfUpper) begin
      primaryCode <= pnCode[63:32];
      secondaryCode <= pnCode[31:0];
    end else begin
      primaryCode <= pnCode[31:0];
      secondaryCode <= pnCode[63:32];
    end
  end

  // ***********************************************************************
  // Symbol pacing
  // ***********************************************************************
  // One tick per code period; a change of code length or double rate restarts the period
  localparam logic [12:0] NORMAL_LAST = 13'(bbr_pkg::NORMAL_BIT_CYCLES - 1);
  localparam logic [12:0] DOUBLE_LAST = 13'(bbr_pkg::DOUBLE_SYM_CYCLES - 1);
  localparam logic [12:0] LONG_LAST = 13'(LONG_BIT_CYCLES - 1);

  logic [12:0] periodLast, periodCnt;
  logic [2:0] lastMode;
  assign periodLast = !len32 ? LONG_LAST : (dbl ? DOUBLE_LAST : NORMAL_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodCnt <= 13'h0000;
      lastMode <= 3'h0;
      symbolTick <= 1'b0;
    end else begin
      lastMode <= {len32, dbl, 1'b0};
      if (lastMode != {len32, dbl, 1'b0}) begin
        periodCnt <= 13'h0000;
        symbolTick <= 1'b0;
      end else if (periodCnt >= periodLast) begin
        periodCnt <= 13'h0000;
        symbolTick <= 1'b1;
      end else begin
        periodCnt <= periodCnt + 13'h0001;
        symbolTick <= 1'b0;
      end
    end
  end

  // ***********************************************************************
  // Interrupt pin
  // ***********************************************************************
  bbr_irq_pin u_irq (
    .clk(clk),
    .nrst(nrst),
    .pinMode(pinCfg[bbr_pkg::PIN_FIELD_LSB +: 2]),
    .irqRequest(irqRequest),
    .irqOut(irqOut),
    .irqOe(irqOe)
  );

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  logic [12:0] tickGap;
  logic gapValid;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickGap <= 13'h0000;
      gapValid <= 1'b0;
    end else begin
      tickGap <= symbolTick ? 13'h0001 : tickGap + 13'h0001;
      if (lastMode != {len32, dbl, 1'b0}) begin
        gapValid <= 1'b0;
      end else if (symbolTick) begin
        gapValid <= 1'b1;
      end
    end
  end

  AST_LEN_SELECT: assert property (@(posedge clk) disable iff (!nrst)
    ##1 chipsPerBit == ($past(rateCfg[2]) ? bbr_pkg::CHIPS_SHORT : bbr_pkg::CHIPS_LONG))
    else $error("chip length does not follow length bit");
  AST_DOUBLE_SHORT: assert property (@(posedge clk) disable iff (!nrst)
    bitsPerSymbol == 2'h2 |-> chipsPerBit == bbr_pkg::CHIPS_SHORT)
    else $error("double rate with long codes");
  AST_DOUBLE_SET: assert property (@(posedge clk) disable iff (!nrst)
    rateCfg[2:1] == 2'h3 |=> bitsPerSymbol == 2'h2)
    else $error("double rate not taken");
  AST_SPLIT_CODE: assert property (@(posedge clk) disable iff (!nrst)
    dbl |=> primaryCode == $past(pnCode[31:0]) && secondaryCode == $past(pnCode[63:32]))
    else $error("double rate code not split");
  AST_TICK_GAP: assert property (@(posedge clk) disable iff (!nrst)
    symbolTick && gapValid |-> tickGap == $past(periodLast) + 13'h0001)
    else $error("symbol period wrong");
  AST_HALF_PICK: assert property (@(posedge clk) disable iff (!nrst)
    len32 && !dbl |=> primaryCode == ($past(halfUpper) ? $past(pnCode[63:32])
                                       : $past(pnCode[31:0])))
    else $error("half select ignored");
  AST_TWO_CODES: assert property (@(posedge clk) disable iff (!nrst)
    len32 && !dbl |=> secondaryCode == ($past(halfUpper) ? $past(pnCode[31:0])
                                         : $past(pnCode[63:32])))
    else $error("second code missing");
  AST_OVS_RULE: assert property (@(posedge clk) disable iff (!nrst)
    oversample == bbr_pkg::OVS_HIGH |-> chipsPerBit == bbr_pkg::CHIPS_SHORT && bitsPerSymbol == 2'h1)
    else $error("12x outside normal short mode");
  AST_OVS_SET: assert property (@(posedge clk) disable iff (!nrst)
    rateCfg[2:0] == 3'h5 |=> oversample == bbr_pkg::OVS_HIGH)
    else $error("12x not selected");

  // ***********************************************************************
  // Decode checks
  // ***********************************************************************
  AST_LEN_LONG: assert property (@(posedge clk) disable iff (!nrst)
    !rateCfg[2] |=> chipsPerBit == bbr_pkg::CHIPS_LONG)
    else $error("long code not selected");
  AST_LONG_SINGLE: assert property (@(posedge clk) disable iff (!nrst)
    !rateCfg[2] |=> bitsPerSymbol == 2'h1)
    else $error("double rate taken with long codes");
  AST_NORMAL_SINGLE: assert property (@(posedge clk) disable iff (!nrst)
    rateCfg[2:1] == 2'h2 |=> bitsPerSymbol == 2'h1)
    else $error("normal rate not one bit per code");
  AST_OVS_LOW: assert property (@(posedge clk) disable iff (!nrst)
    !rateCfg[0] |=> oversample == bbr_pkg::OVS_LOW)
    else $error("6x not selected");
  AST_OVS_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
    (!rateCfg[2] || rateCfg[1]) |=> oversample == bbr_pkg::OVS_LOW)
    else $error("sample bit not ignored");
  AST_INVALID_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    (rateCfg[2:0] == 3'h1 || rateCfg[2:0] == 3'h2) |=> configInvalid)
    else $error("invalid pattern not flagged");
  AST_VALID_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    (rateCfg[2:0] != 3'h1 && rateCfg[2:0] != 3'h2) |=> !configInvalid)
    else $error("valid pattern flagged");
  AST_INVALID_FALLBACK: assert property (@(posedge clk) disable iff (!nrst)
    configInvalid |-> chipsPerBit == bbr_pkg::CHIPS_LONG && oversample == bbr_pkg::OVS_LOW)
    else $error("invalid pattern not decoded as long code");

  // ***********************************************************************
  // Register and code checks
  // ***********************************************************************
  AST_RATE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    regWrite && regAddr == bbr_pkg::ADDR_RATE |=> rateCfg == $past(regWrData))
    else $error("rate register write lost");
  AST_PIN_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    regWrite && regAddr == bbr_pkg::ADDR_PIN |=> pinCfg == $past(regWrData))
    else $error("pin register write lost");
  AST_CTRL_MASK: assert property (@(posedge clk) disable iff (!nrst)
    codeCtrl[7:6] == 2'h0 && codeCtrl[4:0] == 5'h00)
    else $error("control register keeps more than half select");
  AST_HALF_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
    !len32 |=> primaryCode == $past(pnCode[31:0]) && secondaryCode == $past(pnCode[63:32]))
    else $error("half select used with long codes");

  // ***********************************************************************
  // Pacing checks
  // ***********************************************************************
  logic modeSame;
  assign modeSame = lastMode == {len32, dbl, 1'b0};
  AST_TICK_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    symbolTick |=> !symbolTick)
    else $error("symbol tick longer than one cycle");
  AST_TICK_BOUND: assert property (@(posedge clk) disable iff (!nrst)
    modeSame |-> periodCnt <= periodLast)
    else $error("period counter past its end");
  AST_TICK_RESTART: assert property (@(posedge clk) disable iff (!nrst)
    !modeSame |=> periodCnt == 13'h0000 && !symbolTick)
    else $error("mode change did not restart period");
  AST_TICK_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    symbolTick |-> periodCnt == 13'h0000)
    else $error("tick without period restart");

endmodule // bbr_rate_config

/* bbr_spi_slave.sv */
// Serial register port: two-byte frames, address then data
`timescale 1ns/100ps
module bbr_spi_slave (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Serial pins
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // Register side
  output logic [6:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  input wire logic [7:0] regRdData
);

  // ***********************************************************************
  // Synchronisers
  // ***********************************************************************
  logic sclkS1, sclkS2, sclkS3, csS1, csS2, mosiS1, mosiS2;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkS3 <= 1'b0;
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      mosiS1 <= 1'b0;
      mosiS2 <= 1'b0;
    end else begin
      sclkS1 <= spiClk;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      csS1 <= spiCsN;
      csS2 <= csS1;
      mosiS1 <= spiMosi;
      mosiS2 <= mosiS1;
    end
  end

  logic rise, fall;
  assign rise = sclkS2 & ~sclkS3;
  assign fall = ~sclkS2 & sclkS3;

  // ***********************************************************************
  // Frame engine
  // ***********************************************************************
  bbr_pkg::bbr_spi_state_t state;
  logic [2:0] bitCnt;
  logic [7:0] rxShift, txShift, next_byte;
  logic isWrite, loadTx;
  assign next_byte = {rxShift[6:0], mosiS2};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= bbr_pkg::SPI_IDLE;
      bitCnt <= 3'h0;
      rxShift <= 8'h00;
      isWrite <= 1'b0;
      loadTx <= 1'b0;
      regAddr <= 7'h00;
      regWrData <= 8'h00;
      regWrite <= 1'b0;
    end else begin
      regWrite <= 1'b0;
      loadTx <= 1'b0;
      if (csS2) begin
        state <= bbr_pkg::SPI_IDLE;
        bitCnt <= 3'h0;
      end else if (rise) begin
        rxShift <= next_byte;
        bitCnt <= bitCnt + 3'h1;
        case (state)
          bbr_pkg::SPI_IDLE, bbr_pkg::SPI_ADDR: begin
            state <= bbr_pkg::SPI_ADDR;
            if (bitCnt == 3'h7) begin
              isWrite <= next_byte[7];
              regAddr <= next_byte[6:0];
              loadTx <= ~next_byte[7];
              state <= bbr_pkg::SPI_DATA;
            end
          end
          bbr_pkg::SPI_DATA: begin
            if (bitCnt == 3'h7) begin
              regWrData <= next_byte;
              regWrite <= isWrite;
              state <= bbr_pkg::SPI_DONE;
            end
          end
          default: state <= bbr_pkg::SPI_DONE;
        endcase
      end
    end
  end

  // ***********************************************************************
  // Read data out
  // ***********************************************************************
  // Shift only after the first data bit, so bit 7 survives the first fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txShift <= 8'h00;
      spiMiso <= 1'b0;
      spiMisoOe <= 1'b0;
    end else begin
      if (loadTx) begin
        txShift <= regRdData;
      end else if (fall && state == bbr_pkg::SPI_DATA && bitCnt != 3'h0) begin
        txShift <= {txShift[6:0], 1'b0};
      end
      spiMiso <= txShift[7];
      spiMisoOe <= ~csS2 & ~isWrite & (state == bbr_pkg::SPI_DATA);
    end
  end

endmodule // bbr_spi_slave

/* tb.sv */
// Self-checking testbench for the rate and interrupt-pin configuration block
`timescale 1ns/100ps
module tb;
  localparam int LONG_CYC = 50;
  localparam int TIME_LIMIT = 80000;
  logic clk, nrst, spiClk, spiCsN, spiMosi, spiMiso, spiMisoOe;
  logic [63:0] pnCode;
  logic irqRequest, irqOut, irqOe, symbolTick, configInvalid;
  logic [6:0] chipsPerBit;
  logic [1:0] bitsPerSymbol;
  logic [3:0] oversample;
  logic [31:0] primaryCode, secondaryCode;
  logic [7:0] rd;
  logic halfSel;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;

  // ***********************************************************************
  // Clock, timeout, instances
  // ***********************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      err_total++;
      $display("Error timeout expected finish seen hang");
      end_sim();
    end
  end

  bbr_host_model host (.clk(clk), .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));

  bbr_rate_config #(.LONG_BIT_CYCLES(LONG_CYC)) uut (.clk(clk), .nrst(nrst),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .pnCode(pnCode), .irqRequest(irqRequest), .irqOut(irqOut),
    .irqOe(irqOe), .chipsPerBit(chipsPerBit), .bitsPerSymbol(bitsPerSymbol),
    .oversample(oversample), .primaryCode(primaryCode), .secondaryCode(secondaryCode),
    .symbolTick(symbolTick), .configInvalid(configInvalid));

  // ***********************************************************************
  // Checking tasks
  // ***********************************************************************
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_setup(input logic [2:0] r);
    logic len32, dbl, upper;
    len32 = r[2];
    dbl = len32 & r[1];
    upper = len32 & ~dbl & halfSel;
    @(negedge clk);
    chk("chipsPerBit", len32 ? 64'h20 : 64'h40, 64'(chipsPerBit));
    chk("bitsPerSymbol", dbl ? 64'h2 : 64'h1, 64'(bitsPerSymbol));
    chk("oversample", (len32 && !dbl && r[0]) ? 64'hc : 64'h6, 64'(oversample));
    chk("configInvalid", 64'(r == 3'h1 || r == 3'h2), 64'(configInvalid));
    chk("primaryCode", 64'(upper ? pnCode[63:32] : pnCode[31:0]), 64'(primaryCode));
    chk("secondaryCode", 64'(upper ? pnCode[31:0] : pnCode[63:32]), 64'(secondaryCode));
  endtask

  // One-bit expectation first, so a wide cast cannot fill upper bits with ones
  task automatic check_pin(input logic [1:0] m);
    logic expOut;
    expOut = m[1] ? m[0] : (m[0] ~^ irqRequest);
    chk("irqOe", 64'(m[1] ? irqRequest : 1'b1), 64'(irqOe));
    if (!m[1] || irqRequest)
      chk("irqOut", 64'(expOut), 64'(irqOut));
  endtask

  // Cycles between two ticks, waits bounded a little past the period
  task automatic pace(input int period);
    int n;
    n = 0;
    while (symbolTick !== 1'b1 && n < period + 8) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (symbolTick !== 1'b1 && n < period + 8);
    chk("tickPeriod", 64'(period), 64'(n));
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    nrst = 1'b0;
    pnCode = 64'h0;
    irqRequest = 1'b0;
    halfSel = 1'b0;
    void'($urandom(56406));
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check_setup(3'h0);
    check_pin(2'h1);
    host.frame(1'b0, bbr_pkg::ADDR_RATE, 8'h00, rd);
    chk("rateReset", 64'(bbr_pkg::RST_RATE), 64'(rd));
    host.frame(1'b0, bbr_pkg::ADDR_PIN, 8'h00, rd);
    chk("pinReset", 64'(bbr_pkg::RST_PIN), 64'(rd));
    host.frame(1'b0, 7'h10, 8'h00, rd);
    chk("unmappedRead", 64'h0, 64'(rd));
    // Every pattern with both halves; 001 and 010 sent on purpose to see them flagged
    for (int r = 0; r < 16; r++) begin
      halfSel = r[3];
      pnCode = {$urandom, $urandom};
      host.frame(1'b1, bbr_pkg::ADDR_CODE_CTRL, {2'h0, halfSel, 5'h00}, rd);
      host.frame(1'b1, bbr_pkg::ADDR_RATE, 8'(r[2:0]), rd);
      check_setup(r[2:0]);
      host.frame(1'b0, bbr_pkg::ADDR_RATE, 8'h00, rd);
      chk("rateRead", 64'(r[2:0]), 64'(rd));
    end
    host.frame(1'b1, 7'h10, 8'hff, rd);
    host.frame(1'b0, bbr_pkg::ADDR_RATE, 8'h00, rd);
    chk("unmappedWrite", 64'h7, 64'(rd));
    host.frame(1'b1, bbr_pkg::ADDR_CODE_CTRL, 8'hff, rd);
    host.frame(1'b0, bbr_pkg::ADDR_CODE_CTRL, 8'h00, rd);
    chk("ctrlRead", 64'h1 << bbr_pkg::CTRL_HALF_BIT, 64'(rd));
    host.frame(1'b1, bbr_pkg::ADDR_RATE, 8'h04, rd);
    pace(bbr_pkg::NORMAL_BIT_CYCLES);
    host.frame(1'b1, bbr_pkg::ADDR_RATE, 8'h06, rd);
    pace(bbr_pkg::DOUBLE_SYM_CYCLES);
    host.frame(1'b1, bbr_pkg::ADDR_RATE, 8'h00, rd);
    pace(LONG_CYC);
    for (int m = 0; m < 4; m++) begin
      host.frame(1'b1, bbr_pkg::ADDR_PIN, 8'(m), rd);
      for (int k = 0; k < 6; k++) begin
        irqRequest = (k < 2) ? k[0] : 1'($urandom_range(1));
        repeat (2) @(negedge clk);
        check_pin(m[1:0]);
      end
    end
    end_sim();
  end
endmodule // tb
